//--- rtl/mfd_params.svh
`ifndef MFD_PARAMS_SVH
`define MFD_PARAMS_SVH
`define MFD_MAX_TAPS 127
`define MFD_HALF_TAPS 64
`define MFD_DEC_MIN 6'h04
`define MFD_DEC_MAX 6'h3c
`define MFD_DEC_RESET 6'h08
`define MFD_NTAPS_RESET 7'h09
`define MFD_RX_CLK_MHZ 70
`endif

//--- rtl/mfd_pkg.sv
package mfd_pkg;
    typedef struct packed {
        logic [15:0] data;
        logic last;
    } mfd_sample_t;
    typedef struct packed {
        logic [6:0] addr;
        logic [15:0] coef;
    } mfd_coef_wr_t;
    typedef enum logic [0:0] {
        MFD_IDLE,
        MFD_ACC
    } mfd_state_t;
endpackage : mfd_pkg

//--- rtl/mfd_top.sv
`timescale 1ns/1ps
`include "mfd_params.svh"
module mfd_top #(
    parameter int DW = 16,
    parameter int CW = 16,
    parameter int OW = 48
) (
    input wire logic ref_clk_i,
    input wire logic arst_n_i,
    input wire logic coef_we_i,
    input wire mfd_pkg::mfd_coef_wr_t coef_wr_i,
    input wire logic [6:0] ntaps_i,
    input wire logic [5:0] dec_i,
    input wire logic cfg_load_i,
    input wire logic cfg_err_o_unused_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [DW-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [OW-1:0] out_data_o,
    output logic cfg_err_o
);
    // =====================================================
    // Overview.
    // =====================================================
    // Samples enter one per accepted handshake and shift down a delay line of the maximum length.
    // Only the first ntaps_q stages take part in the sum, so a shorter kernel needs no other setting.
    // The coefficient store keeps half of a symmetric kernel plus the centre tap.
    // A mirrored pair of samples is summed first, and that sum is then weighted once.
    // This halves the multipliers, but it also means an asymmetric kernel cannot be expressed.
    // Every dec_q-th accepted sample marks a range gate.
    // The sum for that gate is written to a two-entry output buffer one clock later.
    // By then the marking sample has shifted in, so the result is aligned to it.
    // The buffer lets the sink stall for a whole gate without losing a result.
    // Input is refused only while both buffer entries are full.
    // Neither the delay line nor the coefficient store is reset.
    // A user must load the kernel and flush ntaps_q samples before the results mean anything.
    // A setting that breaks the tap or decimation limits is refused and flagged, and the old one stays.
    // =====================================================
    // Configuration.
    // =====================================================
    logic [CW-1:0] coef_q [0:`MFD_HALF_TAPS-1];
    logic [DW-1:0] dl_q [0:`MFD_MAX_TAPS-1];
    logic [6:0] ntaps_q;
    logic [5:0] dec_q;
    logic cfg_err_q;
    logic [5:0] phase_q;
    logic [OW-1:0] buf_q [0:1];
    logic [1:0] cnt_q;
    logic wr_ptr_q;
    logic rd_ptr_q;
    // Factor must be 4..60 in steps of 4; a factor of one never passes.
    function automatic logic dec_ok(input logic [5:0] d);
        dec_ok = (d >= `MFD_DEC_MIN) && (d <= `MFD_DEC_MAX) && (d[1:0] == 2'h0);
    endfunction : dec_ok
    // Tap count must be odd and at most the maximum.
    function automatic logic taps_ok(input logic [6:0] n);
        taps_ok = n[0] && (n != 7'h00);
    endfunction : taps_ok
    // Sign-extends one sample by a bit, so that a mirrored pair adds without overflow.
    function automatic logic signed [DW:0] sext(input logic [DW-1:0] x);
        sext = $signed({x[DW-1], x});
    endfunction : sext
    wire cfg_good = dec_ok(dec_i) && taps_ok(ntaps_i);
    wire take = in_valid_i && in_ready_o;
    // Input stalls only when the output buffer cannot hold another result.
    assign in_ready_o = (cnt_q != 2'h2);
    // Configuration registers keep the last legal setting.
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ntaps_q <= `MFD_NTAPS_RESET;
            dec_q <= `MFD_DEC_RESET;
            cfg_err_q <= 1'b0;
        end else if (cfg_load_i) begin
            cfg_err_q <= !cfg_good;
            if (cfg_good) begin
                ntaps_q <= ntaps_i;
                dec_q <= dec_i;
            end
        end
    end
    assign cfg_err_o = cfg_err_q;
    // Half coefficient store; tap k and tap N-1-k share one entry.
    always_ff @(posedge ref_clk_i) begin
        if (coef_we_i && (coef_wr_i.addr < 7'(`MFD_HALF_TAPS))) begin
            coef_q[coef_wr_i.addr[5:0]] <= coef_wr_i.coef;
        end
    end
    // =====================================================
    // Delay line, one accepted sample per tap.
    // =====================================================
    always_ff @(posedge ref_clk_i) begin
        if (take) begin
            dl_q[0] <= in_data_i;
            for (int i = 1; i < `MFD_MAX_TAPS; i++) begin
                dl_q[i] <= dl_q[i-1];
            end
        end
    end
    // Symmetric convolution over the taps in use.
    logic signed [OW-1:0] acc;
    always_comb begin
        acc = '0;
        for (int k = 0; k < `MFD_HALF_TAPS; k++) begin
            logic signed [DW:0] pre;
            logic [6:0] mirror;
            pre = '0;
            mirror = 7'(ntaps_q - 7'h01 - 7'(k));
            // Outer taps pair with their mirror; the centre tap stands alone; the rest are unused.
            if (7'(2 * k) < ntaps_q - 7'h01) begin
                pre = sext(dl_q[k]) + sext(dl_q[mirror]);
            end else if (7'(2 * k) == ntaps_q - 7'h01) begin
                pre = sext(dl_q[k]);
            end
            // Coefficients are unsigned, so a zero bit keeps them positive in the signed product.
            acc = OW'(acc + OW'(pre * $signed({1'b0, coef_q[k]})));
        end
    end
    // =====================================================
    // Decimator and two-entry output buffer.
    // =====================================================
    wire dec_hit = take && (phase_q == dec_q - 6'h01);
    wire pop = out_valid_o && out_ready_i;
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            phase_q <= 6'h00;
        end else if (take) begin
            phase_q <= dec_hit ? 6'h00 : phase_q + 6'h01;
        end
    end
    // A hit is delayed by one clock, so the gate's own sample is in the delay line when summed.
    // Gates are at least four samples apart, so one hit is always written before the next.
    logic hit_q;
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            hit_q <= 1'b0;
        end else begin
            hit_q <= dec_hit;
        end
    end
    // Buffer write uses the accumulated value once the new sample has shifted in.
    wire push = hit_q;
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cnt_q <= 2'h0;
            wr_ptr_q <= 1'b0;
            rd_ptr_q <= 1'b0;
        end else begin
            if (push) begin
                wr_ptr_q <= !wr_ptr_q;
            end
            if (pop) begin
                rd_ptr_q <= !rd_ptr_q;
            end
            cnt_q <= 2'(cnt_q + {1'b0, push} - {1'b0, pop});
        end
    end
    always_ff @(posedge ref_clk_i) begin
        if (push) begin
            buf_q[wr_ptr_q] <= acc;
        end
    end
    assign out_valid_o = (cnt_q != 2'h0);
    assign out_data_o = buf_q[rd_ptr_q];
    // =====================================================
    // Checks.
    // =====================================================
    // The held setting always lies inside the legal ranges.
    a_dec_legal: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        dec_ok(dec_q) && taps_ok(ntaps_q)) else $error("Illegal configuration held.");
    a_no_unity: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        dec_q != 6'h01) else $error("Decimation of one held.");
    a_hit_push: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        dec_hit |=> push) else $error("Decimated result not buffered.");
    a_buf_bound: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        cnt_q <= 2'h2) else $error("Output buffer overflow.");
    // A refused setting raises the flag and leaves the old decimation factor in place.
    a_cfg_err: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        cfg_load_i && !cfg_good |=> cfg_err_o && $stable(dec_q)) else $error("Bad setting accepted.");
    // A legal setting is taken whole and clears the flag.
    a_cfg_take: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        cfg_load_i && cfg_good |=> !cfg_err_o && dec_q == $past(dec_i) && ntaps_q == $past(ntaps_i))
        else $error("Legal setting not taken.");
    a_phase_rng: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        phase_q < dec_q) else $error("Decimation phase out of range.");
    // The phase counts accepted samples only, one step each.
    a_phase_step: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        take && !dec_hit |=> phase_q == $past(phase_q) + 6'h01) else $error("Phase did not step.");
    a_phase_wrap: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        dec_hit |=> phase_q == 6'h00) else $error("Phase did not wrap on a gate.");
    a_phase_idle: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        !take |=> $stable(phase_q)) else $error("Phase moved without a sample.");
    a_odd_taps: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        ntaps_q[0]) else $error("Even tap count held.");
    a_stall_full: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        cnt_q == 2'h2 |-> !in_ready_o) else $error("Input taken while buffer full.");
    // A gate result never arrives at a full buffer.
    a_push_room: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        push |-> cnt_q != 2'h2) else $error("Result pushed into a full buffer.");
    // An offered result stays put until the sink takes it.
    a_out_hold: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        out_valid_o && !out_ready_i |=> out_valid_o && $stable(out_data_o)) else $error("Offered result changed.");
    a_full_hold: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        cnt_q == 2'h2 && !out_ready_i |=> !in_ready_o) else $error("Input reopened while stalled.");
endmodule : mfd_top

//--- dv/mfd_sink.sv
`timescale 1ns/1ps
// ==========================================
// Far-side sink of the range-gate stream.
// It stalls on command and keeps every word that it takes.
module mfd_sink (
    input wire logic ref_clk_i,
    input wire logic arst_n_i,
    input wire logic stall_i,
    input wire logic out_valid_i,
    input wire logic [47:0] out_data_i,
    output logic out_ready_o
);
    logic [47:0] got_q[$];
    // Ready follows the stall command one edge late, as a registered sink would.
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) out_ready_o <= 1'b0;
        else out_ready_o <= !stall_i;
    end
    // A word is taken only on an edge with both valid and ready high.
    always @(posedge ref_clk_i) begin
        if (out_valid_i && out_ready_o) got_q.push_back(out_data_i);
    end
endmodule : mfd_sink

//--- dv/testbench.sv
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin fail_count++; $display("CHECK FAILED %0t got %0h", $time, a); end end
// ==========================================
// Self-checking bench for the matched filter and decimator.
module testbench;
    logic ref_clk_i = 1'b0, arst_n_i = 1'b0, coef_we_i = 1'b0, cfg_load_i = 1'b0, in_valid_i = 1'b0, stall = 1'b0;
    mfd_pkg::mfd_coef_wr_t coef_wr_i = '0;
    logic [6:0] ntaps_i = 7'h09;
    logic [5:0] dec_i = 6'h08;
    logic [15:0] in_data_i = 16'h0000;
    logic in_ready_o, out_valid_o, out_ready_i, cfg_err_o;
    logic [47:0] out_data_o;
    int fail_count = 0, cmp_count = 0;
    // The clock runs at 20 MHz.
    always #25 ref_clk_i = ~ref_clk_i;
    mfd_top mfd_top_i (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .coef_we_i(coef_we_i), .coef_wr_i(coef_wr_i),
        .ntaps_i(ntaps_i), .dec_i(dec_i), .cfg_load_i(cfg_load_i), .cfg_err_o_unused_i(1'b0),
        .in_valid_i(in_valid_i), .in_ready_o(in_ready_o), .in_data_i(in_data_i), .out_valid_o(out_valid_o),
        .out_ready_i(out_ready_i), .out_data_o(out_data_o), .cfg_err_o(cfg_err_o));
    mfd_sink mfd_sink_i (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .stall_i(stall),
        .out_valid_i(out_valid_o), .out_data_i(out_data_o), .out_ready_o(out_ready_i));
    // Inputs always move 2 ns after a rising edge.
    task automatic step(input int n);
        repeat (n) @(posedge ref_clk_i);
        #2;
    endtask : step
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : end_sim
    // One sample, held until ready, then an idle cycle so the result stays aligned.
    task automatic send(input logic [15:0] v);
        int n;
        n = 0;
        in_valid_i = 1'b1;
        in_data_i = v;
        while (in_ready_o !== 1'b1 && n < 100) begin
            step(1);
            n++;
        end
        if (n == 100) begin
            fail_count++;
            end_sim();
        end
        step(1);
        in_valid_i = 1'b0;
        step(1);
    endtask : send
    task automatic cfg(input logic [6:0] nt, input logic [5:0] d, input logic err);
        ntaps_i = nt;
        dec_i = d;
        cfg_load_i = 1'b1;
        step(1);
        cfg_load_i = 1'b0;
        step(1);
        `CHK(cfg_err_o, err)
    endtask : cfg
    // A Hanning-edged flat kernel over a steady input gives the coefficient sum times the level.
    task automatic t_sum();
        logic [15:0] w[5] = '{16'h0000, 16'h046c, 16'h0fff, 16'h1b93, 16'h1fff};
        for (int k = 0; k < 5; k++) begin
            coef_we_i = 1'b1;
            coef_wr_i = '{addr: 7'(k), coef: w[k]};
            step(1);
        end
        coef_we_i = 1'b0;
        cfg(7'h09, 6'h08, 1'b0);
        mfd_sink_i.got_q.delete();
        repeat (16) send(16'h0002);
        step(4);
        `CHK(mfd_sink_i.got_q.size(), 2)
        `CHK(mfd_sink_i.got_q[1], 48'h00000000fff6)
        $display("test sum done");
    endtask : t_sum
    // A stalled sink fills both buffer slots, then input is refused until it drains.
    task automatic t_stall();
        stall = 1'b1;
        step(2);
        mfd_sink_i.got_q.delete();
        repeat (16) send(16'h0002);
        step(4);
        `CHK(in_ready_o, 1'b0)
        `CHK(out_valid_o, 1'b1)
        stall = 1'b0;
        step(6);
        `CHK(mfd_sink_i.got_q.size(), 2)
        `CHK(mfd_sink_i.got_q[1], 48'h00000000fff6)
        $display("test stall done");
    endtask : t_stall
    // Legal and illegal configurations, ending on the long-pulse setting.
    task automatic t_cfg();
        cfg(7'h09, 6'h01, 1'b1);
        cfg(7'h09, 6'h3c, 1'b0);
        cfg(7'h09, 6'h06, 1'b1);
        cfg(7'h09, 6'h04, 1'b0);
        cfg(7'h0a, 6'h08, 1'b1);
        cfg(7'h7f, 6'h14, 1'b0);
        cfg(7'h2d, 6'h28, 1'b0);
        cfg(7'h17, 6'h14, 1'b0);
        $display("test cfg done");
    endtask : t_cfg
    // The long-pulse kernel on a fully flushed window, then the shortest decimation, whose ninth tap still holds an old sample under a zero weight.
    task automatic t_long();
        logic [15:0] w[5] = '{16'h0000, 16'h046c, 16'h0fff, 16'h1b93, 16'h1fff};
        for (int k = 0; k < 12; k++) begin
            coef_we_i = 1'b1;
            coef_wr_i = '{addr: 7'(k), coef: (k < 5) ? w[k] : 16'h1fff};
            step(1);
        end
        coef_we_i = 1'b0;
        cfg(7'h17, 6'h14, 1'b0);
        mfd_sink_i.got_q.delete();
        repeat (40) send(16'h0001);
        step(4);
        `CHK(mfd_sink_i.got_q.size(), 2)
        `CHK(mfd_sink_i.got_q[1], 48'h000000023fed)
        cfg(7'h09, 6'h04, 1'b0);
        mfd_sink_i.got_q.delete();
        repeat (8) send(16'h0003);
        step(4);
        `CHK(mfd_sink_i.got_q.size(), 2)
        `CHK(mfd_sink_i.got_q[1], 48'h000000017ff1)
        $display("test long done");
    endtask : t_long
    // Reset for 5 cycles, then the scenarios in turn.
    initial begin
        step(5);
        arst_n_i = 1'b1;
        step(1);
        t_sum();
        t_stall();
        t_cfg();
        t_long();
        end_sim();
    end
endmodule : testbench
